// File: pkg/eie_defs.svh
`ifndef EIE_DEFS_SVH
`define EIE_DEFS_SVH

`define EIE_AW 12
`define EIE_ACCESS_THRESHOLD 8'h5F
`define EIE_ACCESS_SFR_BASE 12'hF00
`define EIE_OP_MOVE_PREFIX 9'h1D7
`define EIE_OP_SECOND_PREFIX 4'hF
`define EIE_OP_PUSH_PREFIX 8'hEA
`define EIE_OP_SUB_PREFIX 8'hE9
`define EIE_SEL_RETURN 2'h3
`define EIE_IND_LO 12'hFDF
`define EIE_IND_HI 12'hFEF
`define EIE_IND_STEP 12'h008
`define EIE_IND_SPAN 12'h005
`define EIE_ZERO_BYTE 8'h00
`define EIE_ZERO_ADDR 12'h000
`define EIE_ONE_ADDR 12'h001

`endif

// File: pkg/eie_pkg.sv
`default_nettype none
package eie_pkg;
	typedef enum logic [1:0] {
		eie_idle = 2'b00,
		eie_move_read = 2'b01,
		eie_move_write = 2'b10,
		eie_ret_nop = 2'b11
	} eie_state_type;
endpackage
`default_nettype wire

// File: logic/eie_indirect_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "eie_defs.svh"
// flags the indirect-data alias registers, found at the top of each pointer's
// special register group; these never hold real data so move accesses to them are nulled
module eie_indirect_check #(
	parameter int AW = `EIE_AW
) (
	input wire logic [AW-1:0] addr,
	output logic is_indirect
);
	logic [2:0] hit;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_grp
			localparam logic [AW-1:0] BASE = AW'(`EIE_IND_LO + g * `EIE_IND_STEP);
			assign hit[g] = (addr >= BASE) && (addr < BASE + AW'(`EIE_IND_SPAN));
		end
	endgenerate
	assign is_indirect = |hit;
endmodule
`default_nettype wire

// File: logic/eie_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "eie_defs.svh"
module eie_core
	import eie_pkg::*;
#(
	parameter int AW = `EIE_AW
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic extended_set_enable,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] mem_rdata,
	input wire logic [AW-1:0] return_stack_top,
	input wire logic [AW-1:0] pointer_zero_in,
	input wire logic [AW-1:0] pointer_one_in,
	output logic [AW-1:0] stack_pointer_reg_two,
	output logic [AW-1:0] file_addr,
	output logic file_dest_is_file,
	output logic [AW-1:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic ptr_wr,
	output logic [1:0] ptr_wr_sel,
	output logic [AW-1:0] ptr_wr_data,
	output logic pc_load,
	output logic [AW-1:0] pc_load_value,
	output logic fetch_stall,
	output logic ext_active
)
;
	eie_state_type state, next_state;
	logic [AW-1:0] next_stack_pointer_reg_two, dst_addr, next_dst_addr;
	logic [AW-1:0] next_file_addr, next_mem_addr, next_ptr_wr_data, next_pc_load_value;
	logic [7:0] next_mem_wdata;
	logic [7:0] src_byte, next_src_byte;
	logic rd_late, next_rd_late;
	logic [1:0] next_ptr_wr_sel;
	logic next_file_dest_is_file, next_mem_rd, next_mem_wr, next_ptr_wr;
	logic next_pc_load, next_fetch_stall, next_ext_active;
	logic src_ind, dst_ind;
	logic [AW-1:0] src_calc, dst_calc;
	logic [AW-1:0] sel_ptr;
	logic [7:0] farg;
	logic is_move, is_push, is_sub, is_second;

	assign farg = instr_word[7:0];
	assign is_move = (instr_word[15:7] == `EIE_OP_MOVE_PREFIX);
	assign is_second = (instr_word[15:12] == `EIE_OP_SECOND_PREFIX);
	assign is_push = (instr_word[15:8] == `EIE_OP_PUSH_PREFIX);
	assign is_sub = (instr_word[15:8] == `EIE_OP_SUB_PREFIX);
	// seven-bit offsets zero-extended, sum wraps in twelve bits
	assign src_calc = stack_pointer_reg_two + AW'(instr_word[6:0]);
	assign dst_calc = stack_pointer_reg_two + AW'(instr_word[6:0]);

	eie_indirect_check #(.AW(AW)) u_src_chk (
		.addr(mem_addr),
		.is_indirect(src_ind)
	);
	eie_indirect_check #(.AW(AW)) u_dst_chk (
		.addr(dst_addr),
		.is_indirect(dst_ind)
	);

	always_comb begin
		case (instr_word[7:6])
			2'h0: sel_ptr = pointer_zero_in;
			2'h1: sel_ptr = pointer_one_in;
			default: sel_ptr = stack_pointer_reg_two;
		endcase
	end

	always_comb begin
		next_state = state;
		next_stack_pointer_reg_two = stack_pointer_reg_two;
		next_dst_addr = dst_addr;
		next_file_addr = file_addr;
		next_file_dest_is_file = file_dest_is_file;
		next_mem_addr = mem_addr;
		next_mem_rd = 1'b0;
		next_mem_wr = 1'b0;
		next_mem_wdata = mem_wdata;
		next_ptr_wr = 1'b0;
		next_ptr_wr_sel = ptr_wr_sel;
		next_ptr_wr_data = ptr_wr_data;
		next_pc_load = 1'b0;
		next_pc_load_value = pc_load_value;
		next_fetch_stall = 1'b0;
		next_ext_active = extended_set_enable;
		// read data stands one cycle only; keep a copy for a late second word
		next_rd_late = mem_rd;
		next_src_byte = rd_late ? mem_rdata : src_byte;
		// standard file address decode runs for every word
		if (!instr_word[8]) begin
			if (extended_set_enable && farg <= `EIE_ACCESS_THRESHOLD) begin
				// with pointer two at zero this lands on the plain access low half
				next_file_addr = stack_pointer_reg_two + AW'(farg);
			end else if (farg <= `EIE_ACCESS_THRESHOLD) begin
				next_file_addr = AW'(farg);
			end else begin
				next_file_addr = `EIE_ACCESS_SFR_BASE | AW'(farg);
			end
		end else begin
			next_file_addr = {bank_select_register, farg};
		end
		next_file_dest_is_file = instr_word[9];
		unique case (state)
			eie_idle: begin
				if (instr_valid && extended_set_enable) begin
					if (is_move) begin
						next_mem_addr = src_calc;
						next_mem_rd = 1'b1;
						next_fetch_stall = 1'b1;
						next_state = eie_move_read;
					end else if (is_push) begin
						next_mem_addr = stack_pointer_reg_two;
						next_mem_wdata = farg;
						next_mem_wr = 1'b1;
						next_stack_pointer_reg_two = stack_pointer_reg_two - `EIE_ONE_ADDR;
						next_ptr_wr = 1'b1;
						next_ptr_wr_sel = 2'h2;
						next_ptr_wr_data = stack_pointer_reg_two - `EIE_ONE_ADDR;
					end else if (is_sub) begin
						next_ptr_wr = 1'b1;
						if (instr_word[7:6] == `EIE_SEL_RETURN) begin
							next_ptr_wr_sel = 2'h2;
							next_ptr_wr_data = stack_pointer_reg_two - AW'(instr_word[5:0]);
							next_stack_pointer_reg_two = next_ptr_wr_data;
							next_pc_load = 1'b1;
							next_pc_load_value = return_stack_top;
							next_fetch_stall = 1'b1;
							next_state = eie_ret_nop;
						end else begin
							next_ptr_wr_sel = instr_word[7:6];
							next_ptr_wr_data = sel_ptr - AW'(instr_word[5:0]);
							if (instr_word[7:6] == 2'h2) begin
								next_stack_pointer_reg_two = next_ptr_wr_data;
							end
						end
					end
				end
			end
			eie_move_read: begin
				// second word arrives now; its low seven bits name the destination
				next_fetch_stall = 1'b1;
				if (instr_valid && is_second) begin
					next_dst_addr = dst_calc;
					next_state = eie_move_write;
				end
			end
			eie_move_write: begin
				// memory read data lands here; the indirect alias reads as zero
				next_mem_wdata = src_ind ? `EIE_ZERO_BYTE : (rd_late ? mem_rdata : src_byte);
				next_mem_addr = dst_addr;
				next_mem_wr = !dst_ind;
				// destination bytes of counter low and return top are not guarded
				next_state = eie_idle;
			end
			eie_ret_nop: begin
				next_state = eie_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= eie_idle;
			stack_pointer_reg_two <= `EIE_ZERO_ADDR;
			dst_addr <= `EIE_ZERO_ADDR;
			file_addr <= `EIE_ZERO_ADDR;
			file_dest_is_file <= 1'b0;
			mem_addr <= `EIE_ZERO_ADDR;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= `EIE_ZERO_BYTE;
			ptr_wr <= 1'b0;
			ptr_wr_sel <= 2'h0;
			ptr_wr_data <= `EIE_ZERO_ADDR;
			pc_load <= 1'b0;
			pc_load_value <= `EIE_ZERO_ADDR;
			fetch_stall <= 1'b0;
			ext_active <= 1'b0;
			rd_late <= 1'b0;
			src_byte <= `EIE_ZERO_BYTE;
		end else begin
			state <= next_state;
			stack_pointer_reg_two <= next_stack_pointer_reg_two;
			dst_addr <= next_dst_addr;
			file_addr <= next_file_addr;
			file_dest_is_file <= next_file_dest_is_file;
			mem_addr <= next_mem_addr;
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			mem_wdata <= next_mem_wdata;
			ptr_wr <= next_ptr_wr;
			ptr_wr_sel <= next_ptr_wr_sel;
			ptr_wr_data <= next_ptr_wr_data;
			pc_load <= next_pc_load;
			pc_load_value <= next_pc_load_value;
			fetch_stall <= next_fetch_stall;
			ext_active <= next_ext_active;
			rd_late <= next_rd_late;
			src_byte <= next_src_byte;
		end
	end
endmodule
`default_nettype wire

// File: tb/eie_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eie_core_asserts (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic extended_set_enable,
	input wire logic [15:0] instr_word,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] return_stack_top,
	input wire logic [11:0] stack_pointer_reg_two,
	input wire logic [11:0] file_addr,
	input wire logic file_dest_is_file,
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic ptr_wr,
	input wire logic [1:0] ptr_wr_sel,
	input wire logic [11:0] ptr_wr_data,
	input wire logic pc_load,
	input wire logic [11:0] pc_load_value
);
	wire logic [7:0] f = instr_word[7:0];
	wire logic acc = instr_word[8];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_banked_map: assert property (acc |=> file_addr == {$past(bank_select_register), $past(f)})
		else $error("banked file address wrong");
	a_access_high: assert property (!acc && f > 8'h5F |=> file_addr == {4'hF, $past(f)})
		else $error("upper access address wrong");
	a_offset_map: assert property (extended_set_enable && !acc && f <= 8'h5F |=>
		file_addr == $past(stack_pointer_reg_two) + $past(f)) else $error("offset address wrong");
	a_plain_access: assert property (!extended_set_enable && !acc && f <= 8'h5F |=>
		file_addr == {4'h0, $past(f)}) else $error("plain access address wrong");
	a_dest_select: assert property (1'b1 |=> file_dest_is_file == $past(instr_word[9]))
		else $error("destination select wrong");
	a_push_step: assert property (mem_wr && ptr_wr |-> ptr_wr_sel == 2'h2
		&& ptr_wr_data == mem_addr - 12'h001) else $error("push pointer step wrong");
	a_pointer_track: assert property (ptr_wr && ptr_wr_sel == 2'h2 |->
		stack_pointer_reg_two == ptr_wr_data) else $error("pointer two not updated");
	a_return_top: assert property (pc_load |-> pc_load_value == $past(return_stack_top)
		&& ptr_wr && ptr_wr_sel == 2'h2) else $error("return load wrong");
	a_return_gap: assert property (pc_load |=> !pc_load && !ptr_wr && !mem_wr)
		else $error("second return cycle not idle");
	a_disabled_quiet: assert property (!extended_set_enable |=> !ptr_wr && !pc_load)
		else $error("extended word acted while disabled");
	cover property (pc_load);
	cover property (mem_wr && ptr_wr);
	cover property (mem_rd ##[1:4] mem_wr);
endmodule
`default_nettype wire

// File: tb/eie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eie_mem_model (
	input wire logic ref_clk,
	input wire logic mem_rd,
	input wire logic [11:0] mem_addr,
	output logic [7:0] mem_rdata,
	output logic [11:0] return_stack_top
);
	initial begin
		mem_rdata = 8'h00;
		return_stack_top = 12'h100;
	end
	// read data holds one cycle only; after that it flips so a late sample is caught
	always @(posedge ref_clk) begin
		mem_rdata <= mem_rd ? mem_addr[7:0] ^ 8'hA5 : ~mem_rdata;
		return_stack_top <= return_stack_top + 12'h13B;
	end
endmodule
`default_nettype wire

// File: tb/extended_indexed_execution_bench.sv
`timescale 1ns/1ps
`default_nettype none
module extended_indexed_execution_bench;
	logic ref_clk = 0, nrst = 0, extended_set_enable = 0, instr_valid = 0, file_dest_is_file;
	logic mem_rd, mem_wr, ptr_wr, pc_load, fetch_stall, ext_active;
	logic [15:0] instr_word = 16'h0000;
	logic [3:0] bank_select_register = 4'h0;
	logic [7:0] mem_rdata, mem_wdata, k;
	logic [1:0] ptr_wr_sel;
	logic [11:0] return_stack_top, stack_pointer_reg_two, file_addr, mem_addr, ptr_wr_data;
	logic [11:0] pointer_zero_in = 12'h000, pointer_one_in = 12'h000, pc_load_value, p, t, a, b;
	logic [6:0] zs_t [3] = '{7'h28, 7'h07, 7'h01};
	logic [6:0] zd_t [3] = '{7'h30, 7'h7F, 7'h17};
	int mismatches = 0, compares = 0, n;
	eie_core u_eie_core (.ref_clk, .nrst, .extended_set_enable, .instr_valid, .instr_word,
		.bank_select_register, .mem_rdata, .return_stack_top, .pointer_zero_in, .pointer_one_in,
		.stack_pointer_reg_two, .file_addr, .file_dest_is_file, .mem_addr, .mem_rd, .mem_wr,
		.mem_wdata, .ptr_wr, .ptr_wr_sel, .ptr_wr_data, .pc_load, .pc_load_value, .fetch_stall,
		.ext_active);
	eie_mem_model u_eie_mem_model (.ref_clk, .mem_rd, .mem_addr, .mem_rdata, .return_stack_top);
	function automatic logic ind(input logic [11:0] x);
		logic [11:0] o;
		o = x - 12'hFDF;
		return o < 12'h015 && o[2:0] < 3'h5;
	endfunction
	task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
		compares++;
		if (got !== ex) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic test_end(input string nm);
		$display("test %s done, mismatches so far %0d", nm, mismatches);
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// caller stands at a falling edge; returns one cycle later with valid still high
	task automatic op(input logic [15:0] w);
		t = return_stack_top;
		instr_word = w;
		instr_valid = 1'b1;
		@(negedge ref_clk);
	endtask
	task automatic decode(input int cnt);
		logic [15:0] w;
		for (int i = 0; i < cnt; i++) begin
			w = {4'h2, 4'($urandom), (i < 2) ? 8'h5F + 8'(i) : 8'($urandom)};
			extended_set_enable = $urandom;
			bank_select_register = $urandom;
			op(w);
			a = w[8] ? {bank_select_register, w[7:0]} : w[7:0] > 8'h5F ? {4'hF, w[7:0]} :
				extended_set_enable ? p + w[7:0] : {4'h0, w[7:0]};
			chk("file_addr", a, file_addr);
			chk("dest bit", w[9], file_dest_is_file);
			chk("ext_active", extended_set_enable, ext_active);
		end
	endtask
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
	initial begin
		void'($urandom(45));
		p = 12'h000;
		repeat (6) @(negedge ref_clk);
		nrst = 1'b1;
		chk("pointer two", p, stack_pointer_reg_two);
		decode(30);
		test_end("decode one");
		extended_set_enable = 1'b0;
		op(16'hEA11);
		chk("disabled push", 12'h000, mem_wr);
		test_end("disabled push");
		extended_set_enable = 1'b1;
		for (int i = 0; i < 40; i++) begin
			k = (i == 0) ? 8'hFF : $urandom;
			op({8'hEA, k});
			chk("push addr", p, mem_addr);
			chk("push data", k, mem_wdata);
			chk("push strobe", 12'h001, mem_wr);
			p = p - 12'h001;
			chk("pointer two", p, stack_pointer_reg_two);
		end
		test_end("push");
		for (int i = 0; i < 3; i++) begin
			a = p + zs_t[i];
			b = p + zd_t[i];
			op({9'h1D7, zs_t[i]});
			chk("move read", a, mem_addr);
			chk("read strobe", 12'h001, mem_rd & fetch_stall);
			op({4'hF, 5'($urandom), zd_t[i]});
			instr_valid = 1'b0;
			n = 0;
			// the write strobe rises one clock after the edge that takes the second word
			repeat (4) begin
				if (mem_wr === 1'b1) begin
					n++;
					chk("move write", b, mem_addr);
					chk("move data", ind(a) ? 12'h000 : a[7:0] ^ 8'hA5, mem_wdata);
				end
				@(negedge ref_clk);
			end
			chk("move writes", !ind(b), n);
		end
		test_end("move");
		decode(30);
		test_end("decode two");
		extended_set_enable = 1'b1;
		for (int s = 0; s < 4; s++) begin
			k = (s == 0) ? 8'h3F : 8'($urandom) & 8'h3F;
			pointer_zero_in = $urandom;
			pointer_one_in = $urandom;
			b = (s == 0) ? pointer_zero_in : (s == 1) ? pointer_one_in : p;
			op({8'hE9, 2'(s), k[5:0]});
			b = b - k;
			chk("sub result", b, ptr_wr_data);
			chk("sub target", (s == 3) ? 12'h002 : 12'(s), ptr_wr_sel);
			chk("return load", s == 3, pc_load);
			if (s == 3)
				chk("return target", t, pc_load_value);
			if (s >= 2)
				p = b;
			op((s == 3) ? 16'hEA55 : 16'h2000);
			chk("idle cycle", 12'h000, mem_wr);
			chk("pointer two", p, stack_pointer_reg_two);
			instr_valid = 1'b0;
			@(negedge ref_clk);
		end
		test_end("subtract");
		give_verdict();
	end
endmodule
bind eie_core eie_core_asserts u_eie_core_asserts (.ref_clk, .nrst, .extended_set_enable,
	.instr_word, .bank_select_register, .return_stack_top, .stack_pointer_reg_two, .file_addr,
	.file_dest_is_file, .mem_addr, .mem_rd, .mem_wr, .ptr_wr, .ptr_wr_sel, .ptr_wr_data,
	.pc_load, .pc_load_value);
`default_nettype wire
